//--- hw/flut_pkg.sv
// Package: register map, field layout and reset values of LUT steps 3 and 4
package flut_pkg;
    // Printed offsets are register indices; byte address is four times each
    localparam logic [7:0] FLUT_IDX_THR3 = 8'h54;
    localparam logic [7:0] FLUT_IDX_DUTY3 = 8'h55;
    localparam logic [7:0] FLUT_IDX_THR4 = 8'h56;
    localparam logic [7:0] FLUT_IDX_DUTY4 = 8'h57;
    localparam int FLUT_ADDR_W = 12;
    localparam logic [11:0] FLUT_ADDR_THR3 = {2'h0, FLUT_IDX_THR3, 2'h0};
    localparam logic [11:0] FLUT_ADDR_DUTY3 = {2'h0, FLUT_IDX_DUTY3, 2'h0};
    localparam logic [11:0] FLUT_ADDR_THR4 = {2'h0, FLUT_IDX_THR4, 2'h0};
    localparam logic [11:0] FLUT_ADDR_DUTY4 = {2'h0, FLUT_IDX_DUTY4, 2'h0};
    localparam logic [7:0] FLUT_THR_RST = 8'h7f;
    localparam logic [7:0] FLUT_DUTY_RST = 8'h3f;
    localparam int FLUT_THR_HALF_BIT = 7;
    localparam int FLUT_DUTY_EXT_LSB = 6;
    localparam int FLUT_DUTY_BASE_W = 6;
    localparam logic [1:0] FLUT_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FLUT_HTRANS_SEQ = 2'h3;
endpackage : flut_pkg

//--- hw/flut_entries.sv
// Registers and threshold compare for fan LUT steps 3 and 4, AHB-Lite slave
`timescale 1ns/1ps
// Summary of operation
// - Low-resolution temperature: threshold top bit ignored, held zero.
// - High-resolution temperature: top bit adds a half degree, 0 to 127.5.
// - Low-resolution temperature: whole-degree compare, 0 to 127.
// - Reading above step-3 threshold, but not step-4, selects step-3 duty for PWM.
// - Reading above step-4 threshold selects step-4 duty likewise.
// - Thresholds are unsigned; sign bit always taken as zero.
// - Table temperature offset is added to thresholds before comparing.
// - Low-resolution duty mode: duty top two bits held zero and ignored.
// - High-resolution duty: top two bits join base six bits, eight-bit duty.
// - Extended duty bits usable only with 22.5 kHz PWM frequency.
// - Low-resolution duty mode: only the base six bits drive PWM.
module flut_entries (
    input wire logic hclk, // Bus clock, 100 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [flut_pkg::FLUT_ADDR_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic hreadyout, // Ready out
    output logic hresp, // Response, always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic temp_hi_res, // Half-degree table mode
    input wire logic duty_hi_res, // Eight-bit duty table mode
    input wire logic pwm_freq_high, // 22.5 kHz PWM selected
    input wire logic table_write_unlock, // Table write enable bit
    input wire logic [8:0] remote_temp, // Remote reading, half degrees
    input wire logic [7:0] table_temp_offset, // Offset, whole degrees
    output logic step3_exceeded, // Reading above step-3 limit
    output logic step4_exceeded, // Reading above step-4 limit
    output logic step_active, // Some step selects duty
    output logic [7:0] pwm_duty // Selected duty value
);
    import flut_pkg::*;

    // Masks built from the package layout so the fields move together
    localparam logic [7:0] THR_LO_MASK = ~(8'h01 << FLUT_THR_HALF_BIT);
    localparam logic [7:0] DUTY_LO_MASK = ~(8'hff << FLUT_DUTY_EXT_LSB);

    logic [7:0] thr3_ff, thr4_ff, duty3_ff, duty4_ff;
    logic [FLUT_ADDR_W-1:0] addr_ff;
    logic wr_ff, rd_ff;
    logic hit3_ff, hit4_ff, act_ff;
    logic [7:0] duty_ff;

    // Address phase decode
    wire logic xfer = hsel && hready && (htrans == FLUT_HTRANS_NONSEQ
                                      || htrans == FLUT_HTRANS_SEQ);
    wire logic sel_t3 = addr_ff == FLUT_ADDR_THR3;
    wire logic sel_d3 = addr_ff == FLUT_ADDR_DUTY3;
    wire logic sel_t4 = addr_ff == FLUT_ADDR_THR4;
    wire logic sel_d4 = addr_ff == FLUT_ADDR_DUTY4;
    wire logic wr_ok = wr_ff && table_write_unlock;
    wire logic ext_en = duty_hi_res && pwm_freq_high;

    // half-degree bit only kept in high-resolution mode
    wire logic [7:0] thr_wmask = temp_hi_res ? 8'hff : THR_LO_MASK;
    // extended duty bits only kept when enabled
    wire logic [7:0] duty_wmask = ext_en ? 8'hff : DUTY_LO_MASK;
    wire logic [7:0] wbyte = hwdata[7:0];

    wire logic [7:0] nxt_thr3 = (wr_ok && sel_t3 ? wbyte : thr3_ff)
                                & thr_wmask;
    wire logic [7:0] nxt_thr4 = (wr_ok && sel_t4 ? wbyte : thr4_ff)
                                & thr_wmask;
    wire logic [7:0] nxt_duty3 = (wr_ok && sel_d3 ? wbyte : duty3_ff)
                                 & duty_wmask;
    wire logic [7:0] nxt_duty4 = (wr_ok && sel_d4 ? wbyte : duty4_ff)
                                 & duty_wmask;

    // unsigned thresholds; half-degree units, top bit the half
    function automatic logic [9:0] thr_half(input logic [7:0] t,
                                            input logic hi);
        logic [9:0] v;
        v = {2'h0, t[6:0], hi & t[FLUT_THR_HALF_BIT]};
        return v;
    endfunction

    // offset applied to both limits, in half degrees
    wire logic [9:0] off_half = {1'b0, table_temp_offset, 1'b0};
    wire logic [9:0] lim3 = thr_half(thr3_ff, temp_hi_res) + off_half;
    wire logic [9:0] lim4 = thr_half(thr4_ff, temp_hi_res) + off_half;
    // low resolution drops the reading's half-degree bit
    wire logic [9:0] rt_cmp = {1'b0, remote_temp[8:1],
                               temp_hi_res & remote_temp[0]};
    wire logic nxt_hit3 = rt_cmp > lim3;
    wire logic nxt_hit4 = rt_cmp > lim4;

    wire logic [7:0] eff3 = ext_en ? duty3_ff : duty3_ff & DUTY_LO_MASK;
    wire logic [7:0] eff4 = ext_en ? duty4_ff : duty4_ff & DUTY_LO_MASK;
    // higher step wins when both limits are exceeded
    wire logic [7:0] nxt_duty = nxt_hit4 ? eff4 : (nxt_hit3 ? eff3 : 8'h00);

    wire logic [7:0] rd_byte = sel_t3 ? thr3_ff : sel_d3 ? duty3_ff :
                               sel_t4 ? thr4_ff : sel_d4 ? duty4_ff : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= '0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (hready) begin
            addr_ff <= haddr;
            wr_ff <= xfer && hwrite;
            rd_ff <= xfer && !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr3_ff <= FLUT_THR_RST & THR_LO_MASK;
            thr4_ff <= FLUT_THR_RST & THR_LO_MASK;
            duty3_ff <= FLUT_DUTY_RST;
            duty4_ff <= FLUT_DUTY_RST;
        end else begin
            thr3_ff <= nxt_thr3;
            thr4_ff <= nxt_thr4;
            duty3_ff <= nxt_duty3;
            duty4_ff <= nxt_duty4;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit3_ff <= 1'b0;
            hit4_ff <= 1'b0;
            act_ff <= 1'b0;
            duty_ff <= 8'h00;
        end else begin
            hit3_ff <= nxt_hit3;
            hit4_ff <= nxt_hit4;
            act_ff <= nxt_hit3 || nxt_hit4;
            duty_ff <= nxt_duty;
        end
    end

    // Zero wait states; unmapped reads return zero, writes are dropped
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_ff ? {24'h0, rd_byte} : 32'h0;
    assign step3_exceeded = hit3_ff;
    assign step4_exceeded = hit4_ff;
    assign step_active = act_ff;
    assign pwm_duty = duty_ff;

    sequence s_locked_write;
        wr_ff && !table_write_unlock;
    endsequence
    sequence s_step4_trip;
        nxt_hit4 ##1 1'b1;
    endsequence
    sequence s_open_write;
        wr_ff && table_write_unlock;
    endsequence
    sequence s_reset_release;
        $rose(hresetn);
    endsequence

    chk_thr_half_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !temp_hi_res |=> !thr3_ff[7] && !thr4_ff[7])
        else $error("Threshold top bit set in low resolution");

    chk_hires_compare: assert property (
        @(posedge hclk) disable iff (!hresetn)
        temp_hi_res && table_temp_offset == 8'h00 |=>
        hit3_ff == ($past(remote_temp) >
                    {1'b0, $past(thr3_ff[6:0]), $past(thr3_ff[7])}))
        else $error("High resolution compare wrong");

    chk_lowres_compare: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !temp_hi_res && table_temp_offset == 8'h00 |=>
        hit4_ff == ($past(remote_temp[8:1]) > {1'b0, $past(thr4_ff[6:0])}))
        else $error("Low resolution compare wrong");

    chk_step3_duty: assert property (
        @(posedge hclk) disable iff (!hresetn)
        nxt_hit3 && !nxt_hit4 |=> step_active && pwm_duty == $past(eff3))
        else $error("Step 3 duty not selected");

    chk_step4_duty: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_step4_trip |-> step4_exceeded && pwm_duty == $past(eff4))
        else $error("Step 4 duty not selected");

    chk_offset_shift: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rt_cmp <= {1'b0, table_temp_offset, 1'b0} |=> !step3_exceeded)
        else $error("Offset not applied to limit");

    chk_duty_ext_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !duty_hi_res |=> duty3_ff[7:6] == 2'h0 && duty4_ff[7:6] == 2'h0)
        else $error("Extended duty bits kept in low resolution");

    chk_ext_freq_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pwm_freq_high |=> pwm_duty[7:6] == 2'h0)
        else $error("Extended duty used below 22.5 kHz");

    chk_hires_duty: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ext_en && nxt_hit4 |=> pwm_duty == $past(duty4_ff))
        else $error("Eight-bit duty not formed");

    chk_lowres_duty: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !duty_hi_res && nxt_hit3 && !nxt_hit4 |=>
        pwm_duty == {2'h0, $past(duty3_ff[5:0])})
        else $error("Low resolution duty not six bits");

    chk_write_lock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_locked_write ##0 temp_hi_res && duty_hi_res && pwm_freq_high
        |=> $stable(thr3_ff) && $stable(duty3_ff)
            && $stable(thr4_ff) && $stable(duty4_ff))
        else $error("Locked write changed a table register");

    chk_write_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_open_write ##0 sel_t3 && temp_hi_res
        |=> thr3_ff == $past(hwdata[7:0]))
        else $error("Unlocked threshold write lost");

    chk_thr_low_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_open_write ##0 sel_t4 && !temp_hi_res
        |=> thr4_ff == {1'b0, $past(hwdata[6:0])})
        else $error("Threshold top bit stored in low resolution");

    chk_duty_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_open_write ##0 sel_d4 && ext_en
        |=> duty4_ff == $past(hwdata[7:0]))
        else $error("Unlocked eight-bit duty write lost");

    chk_duty_low_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_open_write ##0 sel_d3 && !duty_hi_res
        |=> duty3_ff == {2'h0, $past(hwdata[5:0])})
        else $error("Extended duty bits stored in low resolution");

    chk_idle_rdata: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !rd_ff |-> hrdata == 32'h0)
        else $error("Read data outside a read data phase");

    chk_read_upper: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_ff |-> hrdata[31:8] == 24'h0)
        else $error("Read data upper bits not zero");

    // No disable here: this one watches the reset release itself
    chk_reset_vals: assert property (
        @(posedge hclk)
        s_reset_release |-> thr3_ff == (FLUT_THR_RST & THR_LO_MASK)
        && thr4_ff == (FLUT_THR_RST & THR_LO_MASK)
        && duty3_ff == FLUT_DUTY_RST && duty4_ff == FLUT_DUTY_RST
        && !step_active && pwm_duty == 8'h00)
        else $error("Table not at reset values after reset");

    chk_no_step_duty: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !nxt_hit3 && !nxt_hit4 |=> !step_active && pwm_duty == 8'h00)
        else $error("Duty driven with no step exceeded");

    chk_hires_keep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        temp_hi_res && !wr_ok |=> $stable(thr3_ff) && $stable(thr4_ff))
        else $error("Half-degree bit lost in high resolution");

    chk_duty_keep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ext_en && !wr_ok |=> $stable(duty3_ff) && $stable(duty4_ff))
        else $error("Extended duty bits lost while enabled");

    chk_lowres_half: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !temp_hi_res && table_temp_offset == 8'h00
        && remote_temp[8:1] == {1'b0, thr3_ff[6:0]} |=> !step3_exceeded)
        else $error("Half degree counted in low resolution");

    chk_lowres_trip: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !temp_hi_res && table_temp_offset == 8'h00
        && remote_temp[8:1] == {1'b0, thr4_ff[6:0]} + 8'h01 |=> step4_exceeded)
        else $error("One degree above limit did not trip");

    // One half degree above the limit must already trip
    chk_hires_trip: assert property (
        @(posedge hclk) disable iff (!hresetn)
        temp_hi_res && table_temp_offset == 8'h00
        && remote_temp == {1'b0, thr3_ff[6:0], thr3_ff[7]} + 9'h001
        |=> step3_exceeded)
        else $error("Half degree above limit did not trip");

    chk_offset_trip: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !temp_hi_res && {1'b0, remote_temp[8:1]} == {2'h0, thr4_ff[6:0]}
        + {1'b0, table_temp_offset} + 9'h001 |=> step4_exceeded)
        else $error("Offset limit not tripped one degree above");

endmodule // flut_entries

//--- verif/flut_entries_test.sv
// Self-checking bench for the fan LUT step 3 and 4 register bank
`timescale 1ns/1ps
module flut_entries_test;
    import flut_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic temp_hi_res, duty_hi_res, pwm_freq_high, table_write_unlock;
    logic [8:0] remote_temp;
    logic [7:0] table_temp_offset, pwm_duty;
    logic step3_exceeded, step4_exceeded, step_active;
    int n_errors = 0;
    int comparisons = 0;
    int m_reg[4] = '{8'h7f, 8'h3f, 8'h7f, 8'h3f};
    logic [11:0] adr[5] = '{FLUT_ADDR_THR3, FLUT_ADDR_DUTY3,
        FLUT_ADDR_THR4, FLUT_ADDR_DUTY4, 12'h160};
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR %0t: got %h expected %h", $time, g, e); \
    end end

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    flut_entries i_flut_entries (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .temp_hi_res, .duty_hi_res, .pwm_freq_high, .table_write_unlock,
        .remote_temp, .table_temp_offset, .step3_exceeded, .step4_exceeded,
        .step_active, .pwm_duty);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Stored bits outside the active mode are lost, not just hidden
    function automatic int mmask(int i, int v);
        if (i % 2 == 0) return temp_hi_res ? v : v & 'h7f;
        return (duty_hi_res && pwm_freq_high) ? v : v & 'h3f;
    endfunction

    function automatic int lim(int t);
        return ((t & 'h7f) << 1) + (temp_hi_res ? (t >> 7) & 1 : 0)
            + 2 * table_temp_offset;
    endfunction

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: bus never ready", $time);
            print_verdict();
        end
    endtask

    task automatic ahb(input logic wr, input int ai, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= FLUT_HTRANS_NONSEQ;
        haddr <= adr[ai];
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'($urandom()), d};
        wait_rdy();
        rd = hrdata;
        `CHK(hresp, 1'b0)
        if (wr && table_write_unlock && ai < 4) m_reg[ai] = mmask(ai, d);
        if (!wr) `CHK(rd, (ai < 4) ? 32'(m_reg[ai]) : 32'h0)
    endtask

    task automatic check_out;
        int rt;
        logic s3, s4;
        // Low resolution drops the reading's half-degree bit
        rt = temp_hi_res ? remote_temp : remote_temp & 9'h1fe;
        s3 = rt > lim(m_reg[0]);
        s4 = rt > lim(m_reg[2]);
        `CHK(step3_exceeded, s3)
        `CHK(step4_exceeded, s4)
        `CHK(step_active, s3 | s4)
        `CHK(pwm_duty, 8'(s4 ? m_reg[3] : s3 ? m_reg[1] : 0))
    endtask

    task automatic set_mode(logic th, logic dh, logic pf, logic [8:0] t,
        logic [7:0] o);
        temp_hi_res <= th;
        duty_hi_res <= dh;
        pwm_freq_high <= pf;
        remote_temp <= t;
        table_temp_offset <= o;
        repeat (3) @(posedge hclk);
        for (int i = 0; i < 4; i++) m_reg[i] = mmask(i, m_reg[i]);
        check_out();
    endtask

    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {temp_hi_res, duty_hi_res, pwm_freq_high, table_write_unlock} = '0;
        remote_temp = '0;
        table_temp_offset = '0;
        void'($urandom(32'hcd4cfc6e));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) ahb(1'b0, i, 8'h00);
        $display("reset and unmapped read test done");
        ahb(1'b1, 0, 8'h2a);
        ahb(1'b0, 0, 8'h00);
        table_write_unlock <= 1'b1;
        ahb(1'b1, 4, 8'h55);
        ahb(1'b0, 4, 8'h00);
        $display("locked and unmapped write test done");
        ahb(1'b1, 0, 8'h40);
        ahb(1'b1, 1, 8'h15);
        ahb(1'b1, 2, 8'h41);
        ahb(1'b1, 3, 8'hff);
        for (int t = 9'h080; t < 9'h088; t++) begin
            set_mode(0, 0, 0, 9'(t), 0);
            set_mode(1, 1, 1, 9'(t), 0);
            set_mode(0, 0, 0, 9'(t), 1);
        end
        $display("threshold boundary test done");
        for (int n = 0; n < 150; n++) begin
            set_mode(1'($urandom()), 1'($urandom()), 1'($urandom()),
                9'($urandom()), 8'($urandom_range(0, 20)));
            table_write_unlock <= ($urandom_range(0, 3) != 0);
            ahb(1'b1, $urandom_range(0, 4), 8'($urandom()));
            ahb(1'b0, $urandom_range(0, 4), 8'h00);
            repeat (2) @(posedge hclk);
            check_out();
        end
        $display("random mode and compare test done");
        print_verdict();
    end
endmodule // flut_entries_test
